//--- pass_pkg.sv
/*
  Package for the feed motion sequencer: constants, encodings and carriers.
  Assumes a 50 MHz system clock and a synchronous active-high reset.
*/
package pass_pkg;
  localparam int          CLK_HZ         = 50000000;
  localparam int          MS_TICK_CYCLES = CLK_HZ / 1000;
  localparam int          FEEDS          = 4;
  localparam int          FEED_W         = 2;
  localparam int          POS_W          = 16;
  localparam logic [15:0] POS_RESET      = 16'h8000;
  localparam logic [13:0] WAIT_MAX_MS    = 14'h270F;  // 9999 ms
  localparam logic [13:0] FAST_WAIT_RST  = 14'h00FA;  // 250 ms
  localparam logic [13:0] SLOW_WAIT_RST  = 14'h0064;  // 100 ms
  localparam logic [6:0]  SETTLE_MAX     = 7'h64;     // 10.0 s or 10.0 A, tenths
  localparam logic [13:0] CYCLE_MAX      = 14'h270F;  // 9999
  localparam logic [9:0]  DELAY_MAX_S    = 10'h3E7;   // 999 s
  localparam logic [9:0]  MS_PER_S       = 10'h3E8;
  localparam logic [9:0]  MS_PER_TENTH   = 10'h064;
  localparam logic [1:0]  SEL_NONE       = 2'h0;
  localparam logic [1:0]  SEL_STOW       = 2'h1;
  localparam logic [1:0]  SEL_DEPLOY     = 2'h2;
  localparam logic [1:0]  SEL_BOTH       = 2'h3;
  localparam logic [1:0]  SEL_RESET      = SEL_DEPLOY;

  // angles in signed tenths of a degree
  typedef struct packed {
    logic signed [11:0] azim;
    logic signed [11:0] elev;
    logic signed [11:0] feed;
  } pass_target_t;

  typedef struct packed {
    logic [13:0] fast_wait;
    logic [13:0] slow_wait;
    logic [1:0]  select;
    logic signed [11:0] stow;
    logic signed [11:0] deploy;
  } pass_feed_cfg_t;

  typedef struct packed {
    logic cw;
    logic ccw;
    logic fast;
  } pass_drive_t;
endpackage

//--- pass_seq.sv
/*
  Feed position counter, anti-reversal gate, stow/deploy and shake sequencer.
  Assumes the motor drive reports one combined arrival for all axes and that
  pulse, limit and current inputs are asynchronous pins; configuration ports are same-clock.
*/
// Contract
// - every pulse counts by last commanded direction
// - counter-clockwise pulse decrements position count
// - clockwise pulse increments position count
// - hold off opposite drive for wait
// - fast or slow wait by prior speed
// - select 0 moves feed only on shake, 3 always
// - select 1 stow and shake only, 2 deploy and shake only
// - select resets to deploy-only movement
// - hold elevation drive for settle delay
// - current mode drives until threshold reached
// - hold stow and deploy targets, clamped
// - shake visits three targets in order
// - shake repeats configured cycles then stops
// - wait configured delay between shake moves
// - feed settings stored per feed index
// - shake needs expert access enabled
module pass_seq
  import pass_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   reset_in,
  input  wire logic                   pulse_in,
  input  wire logic                   stow_limit_in,
  input  wire logic [6:0]             elev_current_in,
  input  wire pass_drive_t            feed_request_in,
  input  wire logic                   cfg_write_in,
  input  wire logic [FEED_W-1:0]      cfg_index_in,
  input  wire pass_feed_cfg_t         cfg_data_in,
  input  wire logic [FEED_W-1:0]      feed_index_in,
  input  wire pass_target_t           stow_target_in,
  input  wire pass_target_t           deploy_target_in,
  input  wire pass_target_t           shake_target1_in,
  input  wire pass_target_t           shake_target2_in,
  input  wire pass_target_t           shake_target3_in,
  input  wire logic [6:0]             elev_stow_settle_in,
  input  wire logic                   settle_current_mode_in,
  input  wire logic [13:0]            shake_cycles_in,
  input  wire logic [9:0]             shake_delay_in,
  input  wire logic                   expert_in,
  input  wire logic                   stow_start_in,
  input  wire logic                   deploy_start_in,
  input  wire logic                   shake_start_in,
  input  wire logic                   arrived_in,
  output pass_drive_t                 feed_drive_out,
  output logic [POS_W-1:0]            feed_position_out,
  output pass_target_t                move_target_out,
  output logic                        azim_move_out,
  output logic                        elev_move_out,
  output logic                        feed_move_out,
  output logic                        elev_energize_out,
  output logic                        busy_out,
  output logic                        shake_done_out,
  output pass_feed_cfg_t              active_cfg_out
);
  import pass_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_STOW, ST_SETTLE, ST_DEPLOY, ST_SHAKE, ST_DELAY} pass_state_t;

  pass_state_t    state;
  pass_feed_cfg_t cfg_mem [FEEDS];
  logic [2:0]     pulse_sync, limit_sync;
  logic [6:0]     cur_s1, cur_s2, cur_s3;
  logic           last_cw, last_fast, was_driving;
  logic [13:0]    wait_ms;
  logic [15:0]    tick_cnt;
  logic [19:0]    seq_ms;
  logic [1:0]     shake_step;
  logic [13:0]    cycles_left;
  logic [POS_W-1:0] position;
  pass_drive_t    drive;
  pass_target_t   target;

  wire pulse_edge   = pulse_sync[1] & ~pulse_sync[2];
  wire limit_seen   = limit_sync[2];
  // a current word caught mid-change can be torn, so act only on two equal samples
  wire cur_steady   = (cur_s2 == cur_s3);
  wire ms_tick      = (tick_cnt == 16'(MS_TICK_CYCLES - 1));
  wire pass_feed_cfg_t cfg = cfg_mem[feed_index_in];
  wire [13:0] band  = last_fast ? cfg.fast_wait : cfg.slow_wait;
  wire reversing    = (feed_request_in.cw & ~last_cw) | (feed_request_in.ccw & last_cw);
  wire grant        = ~reversing | (wait_ms >= band);
  wire any_req      = feed_request_in.cw ^ feed_request_in.ccw;
  wire feed_on_stow   = (cfg.select == SEL_STOW) | (cfg.select == SEL_BOTH);
  wire feed_on_deploy = (cfg.select == SEL_DEPLOY) | (cfg.select == SEL_BOTH);
  wire [19:0] settle_ms = 20'(elev_stow_settle_in) * 20'(MS_PER_TENTH);
  wire [19:0] delay_ms  = 20'(shake_delay_in) * 20'(MS_PER_S);
  wire [13:0] cycles_eff = (shake_cycles_in == 14'h0000) ? 14'h0001 :
                           (shake_cycles_in > CYCLE_MAX) ? CYCLE_MAX : shake_cycles_in;
  wire pass_target_t shake_sel = (shake_step == 2'h0) ? shake_target1_in :
                                 (shake_step == 2'h1) ? shake_target2_in : shake_target3_in;

  // clamp one angle to its range
  function automatic logic signed [11:0] clamp(input logic signed [11:0] v, input logic signed [11:0] lo,
                                               input logic signed [11:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // synchronisers: first stage feeds only the second
  always_ff @(posedge clock_in) begin
    pulse_sync <= {pulse_sync[1:0], pulse_in};
    limit_sync <= {limit_sync[1:0], stow_limit_in};
    cur_s1     <= elev_current_in;
    cur_s2     <= cur_s1;
    cur_s3     <= cur_s2;
  end

  // millisecond tick from the system clock
  always_ff @(posedge clock_in) begin
    if (reset_in | ms_tick) tick_cnt <= 16'h0000;
    else tick_cnt <= tick_cnt + 16'h0001;
  end

  generate
    for (genvar i = 0; i < FEEDS; i++) begin : g_feed
      always_ff @(posedge clock_in) begin
        if (reset_in) begin
          cfg_mem[i] <= '{FAST_WAIT_RST, SLOW_WAIT_RST, SEL_RESET, 12'sh000, 12'sh000};
        end else if (cfg_write_in && cfg_index_in == FEED_W'(i)) begin
          cfg_mem[i].fast_wait <= (cfg_data_in.fast_wait > WAIT_MAX_MS) ? WAIT_MAX_MS : cfg_data_in.fast_wait;
          cfg_mem[i].slow_wait <= (cfg_data_in.slow_wait > WAIT_MAX_MS) ? WAIT_MAX_MS : cfg_data_in.slow_wait;
          cfg_mem[i].select    <= cfg_data_in.select;
          cfg_mem[i].stow      <= clamp(cfg_data_in.stow, -12'sd1800, 12'sd1800);
          cfg_mem[i].deploy    <= clamp(cfg_data_in.deploy, -12'sd1800, 12'sd1800);
        end
      end
    end
  endgenerate

  // direction memory and reversal timer
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      last_cw     <= 1'b1;
      last_fast   <= 1'b0;
      was_driving <= 1'b0;
      wait_ms     <= 14'h0000;
      drive       <= '0;
    end else begin
      drive.cw    <= any_req & grant & feed_request_in.cw;
      drive.ccw   <= any_req & grant & feed_request_in.ccw;
      drive.fast  <= any_req & grant & feed_request_in.fast;
      was_driving <= drive.cw | drive.ccw;
      if (drive.cw | drive.ccw) begin
        last_cw   <= drive.cw;
        last_fast <= drive.fast;
        wait_ms   <= 14'h0000;
      end else if (ms_tick && wait_ms != WAIT_MAX_MS) begin
        wait_ms <= wait_ms + 14'h0001;
      end
    end
  end

  // count on every pulse, idle or not
  always_ff @(posedge clock_in) begin
    if (reset_in) position <= POS_RESET;
    else if (pulse_edge) begin
      if (last_cw) position <= position + 16'h0001;
      else position <= position - 16'h0001;
    end
  end

  // sequencer; a new start is ignored while busy
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state          <= ST_IDLE;
      seq_ms         <= 20'h00000;
      shake_step     <= 2'h0;
      cycles_left    <= 14'h0000;
      shake_done_out <= 1'b0;
      target         <= '0;
      feed_move_out  <= 1'b0;
    end else begin
      shake_done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          seq_ms <= 20'h00000;
          if (stow_start_in) begin
            state  <= ST_STOW;
            target <= '{clamp(stow_target_in.azim, -12'sd1800, 12'sd1800),
                        clamp(stow_target_in.elev, -12'sd900, 12'sd1200), cfg.stow};
            feed_move_out <= feed_on_stow;
          end else if (deploy_start_in) begin
            state  <= ST_DEPLOY;
            target <= '{clamp(deploy_target_in.azim, -12'sd1800, 12'sd1800),
                        clamp(deploy_target_in.elev, -12'sd900, 12'sd900), cfg.deploy};
            feed_move_out <= feed_on_deploy;
          end else if (shake_start_in && expert_in) begin
            state         <= ST_SHAKE;
            shake_step    <= 2'h0;
            cycles_left   <= cycles_eff;
            feed_move_out <= 1'b1;
          end
        end
        ST_STOW: if (limit_seen) begin
          state  <= ST_SETTLE;
          seq_ms <= 20'h00000;
        end
        ST_SETTLE: begin
          if (ms_tick) seq_ms <= seq_ms + 20'h00001;
          if (settle_current_mode_in) begin
            if (cur_steady && cur_s2 >= elev_stow_settle_in) state <= ST_IDLE;
          end else if (seq_ms >= settle_ms) begin
            state <= ST_IDLE;
          end
        end
        ST_DEPLOY: if (arrived_in) state <= ST_IDLE;
        ST_SHAKE: begin
          target <= '{clamp(shake_sel.azim, -12'sd1800, 12'sd1800),
                      clamp(shake_sel.elev, -12'sd900, 12'sd900),
                      clamp(shake_sel.feed, -12'sd1800, 12'sd1800)};
          if (arrived_in) begin
            seq_ms <= 20'h00000;
            if (shake_step == 2'h2) begin
              shake_step  <= 2'h0;
              cycles_left <= cycles_left - 14'h0001;
            end else begin
              shake_step <= shake_step + 2'h1;
            end
            if (shake_step == 2'h2 && cycles_left == 14'h0001) begin
              state          <= ST_IDLE;
              shake_done_out <= 1'b1;
            end else begin
              state <= ST_DELAY;
            end
          end
        end
        ST_DELAY: begin
          if (ms_tick) seq_ms <= seq_ms + 20'h00001;
          if (seq_ms >= delay_ms) state <= ST_SHAKE;
        end
        default: state <= ST_IDLE;
      endcase
      if (state != ST_IDLE && state != ST_SHAKE && state != ST_DELAY && (stow_start_in | deploy_start_in)) begin
        feed_move_out <= feed_move_out;
      end else if (state == ST_IDLE && !(stow_start_in | deploy_start_in | (shake_start_in & expert_in))) begin
        feed_move_out <= 1'b0;
      end
    end
  end

  // outputs
  assign feed_drive_out    = drive;
  assign feed_position_out = position;
  assign move_target_out   = target;
  assign azim_move_out     = (state == ST_STOW) | (state == ST_DEPLOY) | (state == ST_SHAKE);
  assign elev_move_out     = azim_move_out;
  assign elev_energize_out = (state == ST_STOW) | (state == ST_SETTLE) | (state == ST_DEPLOY) | (state == ST_SHAKE);
  assign busy_out          = (state != ST_IDLE);
  assign active_cfg_out    = cfg;

  // counter and reversal checks
  a_reverse_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    (drive.cw && !was_driving && !last_cw) |-> ($past(wait_ms) >= $past(band)))
    else $error("reversal granted before wait");
  a_wait_speed: assert property (@(posedge clock_in) disable iff (reset_in)
    (drive.ccw && !was_driving && last_cw) |->
      ($past(wait_ms) >= ($past(last_fast) ? $past(cfg.fast_wait) : $past(cfg.slow_wait))))
    else $error("reversal wait ignored prior speed");
  a_drive_single: assert property (@(posedge clock_in) disable iff (reset_in)
    !(drive.cw && drive.ccw))
    else $error("both drive directions asserted");
  a_wait_limit: assert property (@(posedge clock_in) disable iff (reset_in)
    (wait_ms <= WAIT_MAX_MS))
    else $error("reversal timer ran past its limit");
  a_count_up: assert property (@(posedge clock_in) disable iff (reset_in)
    (pulse_edge && last_cw) |=> (position == $past(position) + 16'h0001))
    else $error("clockwise pulse did not increment");
  a_count_down: assert property (@(posedge clock_in) disable iff (reset_in)
    (pulse_edge && !last_cw) |=> (position == $past(position) - 16'h0001))
    else $error("ccw pulse did not decrement");
  a_count_idle: assert property (@(posedge clock_in) disable iff (reset_in)
    (pulse_edge && !drive.cw && !drive.ccw) |=> (position != $past(position)))
    else $error("idle pulse was lost");
  a_count_still: assert property (@(posedge clock_in) disable iff (reset_in)
    !pulse_edge |=> (position == $past(position)))
    else $error("position moved without a pulse");

  // sequencer checks
  a_shake_expert: assert property (@(posedge clock_in) disable iff (reset_in)
    ($rose(state == ST_SHAKE) && $past(state) == ST_IDLE) |-> $past(expert_in))
    else $error("shake started without expert access");
  a_settle_energized: assert property (@(posedge clock_in) disable iff (reset_in)
    (state == ST_SETTLE) |-> elev_energize_out)
    else $error("elevation released during settle");
  a_settle_time: assert property (@(posedge clock_in) disable iff (reset_in)
    ($past(state) == ST_SETTLE && state == ST_IDLE && !$past(settle_current_mode_in)) |->
      ($past(seq_ms) >= $past(settle_ms)))
    else $error("settle delay cut short");
  a_settle_current: assert property (@(posedge clock_in) disable iff (reset_in)
    ($past(state) == ST_SETTLE && state == ST_IDLE && $past(settle_current_mode_in)) |->
      ($past(cur_s2) >= $past(elev_stow_settle_in)))
    else $error("settle ended below current threshold");
  a_feed_stow_gate: assert property (@(posedge clock_in) disable iff (reset_in)
    ($past(state) == ST_IDLE && state == ST_STOW) |-> (feed_move_out == $past(feed_on_stow)))
    else $error("feed moved without permission");
  a_feed_deploy_gate: assert property (@(posedge clock_in) disable iff (reset_in)
    ($past(state) == ST_IDLE && state == ST_DEPLOY) |-> (feed_move_out == $past(feed_on_deploy)))
    else $error("feed deploy move not per selector");
  a_feed_held: assert property (@(posedge clock_in) disable iff (reset_in)
    (state != ST_IDLE && $past(state) != ST_IDLE) |-> $stable(feed_move_out))
    else $error("feed permission changed mid-sequence");
  a_stow_range: assert property (@(posedge clock_in) disable iff (reset_in)
    (state == ST_STOW) |-> (target.elev <= 12'sd1200 && target.elev >= -12'sd900))
    else $error("stow elevation target out of range");
  a_shake_range: assert property (@(posedge clock_in) disable iff (reset_in)
    ($past(state) == ST_SHAKE) |-> (target.azim <= 12'sd1800 && target.azim >= -12'sd1800))
    else $error("shake azimuth target out of range");
  a_shake_delay: assert property (@(posedge clock_in) disable iff (reset_in)
    ($past(state) == ST_DELAY && state == ST_SHAKE) |-> ($past(seq_ms) >= $past(delay_ms)))
    else $error("shake move started before delay");
  a_shake_cycles: assert property (@(posedge clock_in) disable iff (reset_in)
    shake_done_out |-> (state == ST_IDLE && $past(cycles_left) == 14'h0001))
    else $error("shake stopped on wrong cycle");

  // scenario covers
  c_stow: cover property (@(posedge clock_in) state == ST_SETTLE ##1 state == ST_IDLE);
  c_shake: cover property (@(posedge clock_in) shake_done_out);
  c_reverse: cover property (@(posedge clock_in) drive.ccw ##[1:20] drive.cw);
  c_deploy_feed: cover property (@(posedge clock_in) state == ST_DEPLOY && feed_move_out);
  c_current: cover property (@(posedge clock_in) state == ST_SETTLE && settle_current_mode_in ##1 state == ST_IDLE);
endmodule

//--- pass_drive_model.sv
/*
  Behavioural motor drive and feed pulse sensor facing the sequencer.
  Assumes one clock shared with the sequencer and a synchronous active-high reset.
*/
module pass_drive_model
  import pass_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire pass_drive_t drive_in,
  input  wire logic        coast_in,
  input  wire logic        move_in,
  output logic             pulse_out,
  output logic             arrived_out,
  output int               pulses_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div;
  logic [3:0] lag;
  // the shaft turns while driven, and also while coasting after the drive drops
  wire        spin = drive_in.cw | drive_in.ccw | coast_in;

  // sensor: one pulse per eight cycles of rotation, counted at its rising edge
  always_ff @(posedge clock_in) begin
    div       <= (reset_in | !spin) ? 3'h0 : div + 3'h1;
    pulse_out <= !reset_in & spin & div[2];
    if (reset_in)
      pulses_out <= 0;
    else if (spin && div == 3'h4)
      pulses_out <= pulses_out + 1;
  end

  // arrival: the axis reaches its target fifteen cycles after move_in rises, then every sixteen while it stays high
  always_ff @(posedge clock_in) begin
    lag         <= (reset_in | !move_in) ? 4'h0 : lag + 4'h1;
    arrived_out <= !reset_in & move_in & (lag == 4'hE);
  end
endmodule

//--- pass_seq_bench.sv
/*
  Self-checking bench for the feed motion sequencer.
  Assumes the drive model beside it; inputs change on the falling clock edge.
*/
module pass_seq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pass_pkg::*;
  logic             clk, rst = 1, pulse, arr, lim = 0, cfg_wr = 0, coast = 0, exp_en = 0, cmode = 0;
  logic             st_s = 0, st_d = 0, st_k = 0, amv, emv, fmv, eng, busy, done;
  logic [6:0]       cur = 7'h00, settle = 7'h00;
  logic [1:0]       cidx = 2'h0, fidx = 2'h0;
  logic [13:0]      ncyc = 14'h0002;
  logic [9:0]       dly = 10'h000;
  logic [POS_W-1:0] pos;
  pass_drive_t      req = '0, drv;
  pass_feed_cfg_t   cfg = '0, acfg;
  pass_target_t     tz = '0, tgt;
  int               error_cnt = 0, n_checks = 0, npul, n_arr = 0, i;

  // clock at 50 MHz
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  pass_seq u_dut (.clock_in(clk), .reset_in(rst), .pulse_in(pulse), .stow_limit_in(lim),
    .elev_current_in(cur), .feed_request_in(req), .cfg_write_in(cfg_wr), .cfg_index_in(cidx),
    .cfg_data_in(cfg), .feed_index_in(fidx), .stow_target_in(tz), .deploy_target_in(tz),
    .shake_target1_in(tz), .shake_target2_in(tz), .shake_target3_in(tz),
    .elev_stow_settle_in(settle), .settle_current_mode_in(cmode), .shake_cycles_in(ncyc),
    .shake_delay_in(dly), .expert_in(exp_en), .stow_start_in(st_s), .deploy_start_in(st_d),
    .shake_start_in(st_k), .arrived_in(arr), .feed_drive_out(drv), .feed_position_out(pos),
    .move_target_out(tgt), .azim_move_out(amv), .elev_move_out(emv), .feed_move_out(fmv),
    .elev_energize_out(eng), .busy_out(busy), .shake_done_out(done), .active_cfg_out(acfg));

  pass_drive_model u_drive (.clock_in(clk), .reset_in(rst), .drive_in(drv), .coast_in(coast),
    .move_in(amv | emv | fmv), .pulse_out(pulse), .arrived_out(arr), .pulses_out(npul));

  // arrivals seen by the sequencer, for the shake move count
  always @(posedge clk) if (arr) n_arr <= n_arr + 1;

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one write of a feed's settings; slow wait is always zero here
  task automatic wcfg(input logic [1:0] idx, input logic [13:0] fw, input logic [1:0] sel);
    cidx = idx;
    cfg = '{fw, 14'h0000, sel, 12'sh064, 12'shF9C};
    cfg_wr = 1;
    cyc(1);
    cfg_wr = 0;
  endtask

  task automatic t_reset();
    chk(pos === POS_RESET && drv === '0, "reset position or drive");
    chk(acfg.select === SEL_RESET, "reset selector");
    chk(acfg.fast_wait === FAST_WAIT_RST && acfg.slow_wait === SLOW_WAIT_RST, "reset waits");
    wcfg(2'h1, 14'h0002, SEL_BOTH);
    fidx = 2'h1;
    cyc(1);
    chk(acfg.select === SEL_BOTH && acfg.fast_wait === 14'h0002, "feed 1 settings");
    fidx = 2'h0;
    cyc(1);
    chk(acfg.select === SEL_RESET, "feed 0 kept");
    $display("test reset done");
  endtask

  // drive one way, stop, then let the shaft coast with the drive idle
  task automatic run_coast(input pass_drive_t r, output int n);
    int n0;
    n0 = npul;
    req = r;
    cyc(62);
    req = '0;
    cyc(10);
    coast = 1;
    cyc(24);
    coast = 0;
    cyc(12);
    n = npul - n0;
  endtask

  task automatic t_count();
    logic [15:0] p;
    int n;
    wcfg(2'h0, 14'h0002, SEL_NONE);
    p = pos;
    run_coast(3'b100, n);
    chk(n > 0 && pos === p + 16'(n), "cw count");
    p = pos;
    req = 3'b010;
    cyc(2);
    chk(drv.ccw === 1'b1, "slow reversal with zero wait");
    run_coast(3'b010, n);
    chk(n > 0 && pos === p - 16'(n), "ccw count");
    $display("test count done");
  endtask

  task automatic t_fast();
    logic early;
    early = 0;
    req = 3'b101;
    cyc(20);
    req = 3'b011;
    for (i = 0; i < 49000; i++) begin
      cyc(1);
      if (drv.ccw !== 1'b0) early = 1;
    end
    chk(!early, "reversal not held off");
    for (i = 0; i < 52000 && drv.ccw !== 1'b1; i++) cyc(1);
    chk(drv.ccw === 1'b1, "reversal never granted");
    req = '0;
    cyc(10);
    $display("test reversal done");
  endtask

  task automatic t_stow();
    // every target out of range, so azimuth and elevation each show their own clamp
    tz = {3{12'h7D0}};
    for (int s = 0; s < 4; s++) begin
      wcfg(2'h0, 14'h0002, 2'(s));
      st_s = 1;
      cyc(1);
      st_s = 0;
      cyc(1);
      chk(busy === 1'b1 && fmv === s[0], "stow feed move");
      chk(tgt === {12'h708, 12'h4B0, 12'h064} && amv === 1'b1 && emv === 1'b1, "stow target");
      lim = 1;
      for (i = 0; i < 20 && busy !== 1'b0; i++) cyc(1);
      chk(busy === 1'b0 && eng === 1'b0, "stow end with no settle");
      lim = 0;
      st_d = 1;
      cyc(1);
      st_d = 0;
      cyc(1);
      chk(busy === 1'b1 && fmv === s[1], "deploy feed move");
      chk(tgt === {12'h708, 12'h384, 12'hF9C}, "deploy target");
      for (i = 0; i < 200 && busy !== 1'b0; i++) cyc(1);
      chk(busy === 1'b0, "deploy end");
    end
    $display("test stow done");
  endtask

  task automatic t_current();
    settle = 7'h05;
    cmode = 1;
    st_s = 1;
    cyc(1);
    st_s = 0;
    lim = 1;
    cyc(20);
    chk(eng === 1'b1 && busy === 1'b1, "held below threshold");
    cur = 7'h05;
    for (i = 0; i < 10 && eng !== 1'b0; i++) cyc(1);
    chk(eng === 1'b0 && busy === 1'b0, "released at threshold");
    lim = 0;
    cmode = 0;
    settle = 7'h00;
    cyc(2);
    $display("test current done");
  endtask

  task automatic t_shake();
    int a;
    logic seen;
    seen = 0;
    st_k = 1;
    cyc(1);
    st_k = 0;
    cyc(2);
    chk(busy === 1'b0, "shake without expert access");
    exp_en = 1;
    a = n_arr;
    st_k = 1;
    cyc(1);
    st_k = 0;
    for (i = 0; i < 400 && !seen; i++) begin
      @(posedge clk);
      #1 seen = (done === 1'b1);
    end
    chk(seen && n_arr - a == 6, "two cycles of three moves");
    chk(tgt === {12'h708, 12'h384, 12'h708}, "shake target clamp");
    cyc(40);
    chk(busy === 1'b0 && n_arr - a == 6, "shake kept moving");
    $display("test shake done");
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence: reset for 20 cycles, let the synchronisers fill, then the tests
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    cyc(4);
    t_reset();
    t_count();
    t_fast();
    t_stow();
    t_current();
    t_shake();
    final_report();
  end

  // watchdog: the tests need about 2.0 ms, mostly the reversal hold-off
  initial begin
    #3000000;
    error_cnt++;
    final_report();
  end
endmodule
